/* common/ras_pkg.sv */
/*
 package for the return address stack: register offsets, field positions,
 reset values, operation codes and the packed carriers shared with the core.
 assumes a single 100 MHz core clock and an AXI4-Lite master for software.
*/
package ras_pkg;
   localparam int unsigned RAS_DEPTH       = 31;
   localparam int unsigned RAS_AW          = 21;
   localparam int unsigned RAS_PW          = 5;
   // register byte offsets
   localparam logic [7:0]  RAS_OFS_PTR     = 8'h00;
   localparam logic [7:0]  RAS_OFS_TOP_LO  = 8'h04;
   localparam logic [7:0]  RAS_OFS_TOP_HI  = 8'h08;
   localparam logic [7:0]  RAS_OFS_TOP_UP  = 8'h0C;
   localparam logic [7:0]  RAS_OFS_CTRL    = 8'h10;
   // pointer and control register fields
   localparam int unsigned RAS_BIT_FULL    = 7;
   localparam int unsigned RAS_BIT_UNDER   = 6;
   localparam int unsigned RAS_BIT_ORE     = 0;
   localparam logic [7:0]  RAS_PTR_RESET   = 8'h00;
   localparam logic        RAS_ORE_RESET   = 1'b1;
   localparam logic [RAS_PW-1:0] RAS_PTR_MAX = 5'h1F;
   localparam logic [RAS_AW-1:0] RAS_PC_STEP = 21'h000002;
   localparam logic [1:0]  RAS_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RAS_RESP_SLVERR = 2'h2;

   // stack operation requested by the core in one cycle
   typedef enum logic [1:0] {RAS_OP_NONE, RAS_OP_PUSH, RAS_OP_POP, RAS_OP_DROP} ras_op_e;

   // fast shadow set: status, working, bank select
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] working;
      logic [7:0] bank;
   } ras_shadow_s;

   // request from the execution and interrupt logic
   typedef struct packed {
      ras_op_e           op;
      logic [RAS_AW-1:0] pc;
      logic              fast_save;
      logic              fast_restore;
   } ras_req_s;
endpackage

/* verilog/ras_stack.sv */
/*
 return address stack with top-of-entry access, full and underflow flags,
 optional device reset request, and a one-level fast register shadow.
 assumes the core decodes instructions into ras_req_s (calls, interrupt
 acknowledge and push map to push, returns to pop, the pop instruction to drop)
 and that software reaches the registers over AXI4-Lite on the same clock.
*/
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
module ras_stack
   import ras_pkg::*;
(
   // clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic                  por_n,
   // core side
   input  wire ras_pkg::ras_req_s     req,
   input  wire logic                  irq_vector,
   input  wire ras_pkg::ras_shadow_s  live_regs,
   output logic [ras_pkg::RAS_AW-1:0] pop_pc,
   output logic                       pop_valid,
   output ras_pkg::ras_shadow_s       shadow_regs,
   output logic                       shadow_restore,
   output logic                       device_reset_req,
   // axi4-lite slave
   input  wire logic [7:0]            s_awaddr,
   input  wire logic                  s_awvalid,
   output logic                       s_awready,
   input  wire logic [31:0]           s_wdata,
   input  wire logic [3:0]            s_wstrb,
   input  wire logic                  s_wvalid,
   output logic                       s_wready,
   output logic [1:0]                 s_bresp,
   output logic                       s_bvalid,
   input  wire logic                  s_bready,
   input  wire logic [7:0]            s_araddr,
   input  wire logic                  s_arvalid,
   output logic                       s_arready,
   output logic [31:0]                s_rdata,
   output logic [1:0]                 s_rresp,
   output logic                       s_rvalid,
   input  wire logic                  s_rready
);
   import ras_pkg::*;

   logic [RAS_AW-1:0] mem [1:RAS_DEPTH];
   logic [RAS_PW-1:0] ptr;
   logic              full_flag;
   logic              under_flag;
   logic              ore;
   ras_shadow_s       shadow;

   // write channel capture: address and data may arrive in either order
   logic              aw_held;
   logic              w_held;
   logic [7:0]        aw_addr;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;

   // byte merge used by the low and high top entry registers
   function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw,
                                         input logic en);
      merge8 = en ? nw : old;
   endfunction

   // register map membership, shared by the write and read decoders
   function automatic logic ras_mapped(input logic [7:0] a);
      ras_mapped = a inside {RAS_OFS_PTR, RAS_OFS_TOP_LO, RAS_OFS_TOP_HI,
                             RAS_OFS_TOP_UP, RAS_OFS_CTRL};
   endfunction

   // core decode
   wire do_push  = (req.op == RAS_OP_PUSH);
   wire do_pop   = (req.op == RAS_OP_POP);
   wire do_drop  = (req.op == RAS_OP_DROP);
   wire at_empty = (ptr == '0);
   wire at_full  = (ptr == RAS_PTR_MAX);
   wire at_edge  = (ptr == RAS_PTR_MAX - 5'h01);
   wire push_ovf = do_push && at_edge && ore;
   wire push_blk = do_push && at_full;
   wire pop_unf  = (do_pop || do_drop) && at_empty;

   // register write decode
   wire wr_fire  = aw_held && w_held && !s_bvalid;
   wire wr_ptr   = wr_fire && aw_addr == RAS_OFS_PTR && w_strb[0];
   wire wr_lo    = wr_fire && aw_addr == RAS_OFS_TOP_LO;
   wire wr_hi    = wr_fire && aw_addr == RAS_OFS_TOP_HI;
   wire wr_up    = wr_fire && aw_addr == RAS_OFS_TOP_UP;
   wire wr_ctrl  = wr_fire && aw_addr == RAS_OFS_CTRL && w_strb[0];
   wire wr_map   = ras_mapped(aw_addr);

   // top entry view; slot zero reads as zero
   wire [RAS_AW-1:0] top_val   = at_empty ? '0 : mem[ptr];
   wire [7:0]        ptr_view  = {full_flag, under_flag, 1'b0, ptr};
   wire [RAS_PW-1:0] ptr_inc   = ptr + 5'h01;
   wire [RAS_PW-1:0] ptr_dec   = ptr - 5'h01;
   wire [RAS_AW-1:0] push_data = push_ovf ? req.pc + RAS_PC_STEP : req.pc;

   // read data decode
   logic [31:0] rd_mux;
   always_comb begin
      case (s_araddr)
         RAS_OFS_PTR:    rd_mux = {24'h000000, ptr_view};
         RAS_OFS_TOP_LO: rd_mux = {24'h000000, top_val[7:0]};
         RAS_OFS_TOP_HI: rd_mux = {24'h000000, top_val[15:8]};
         RAS_OFS_TOP_UP: rd_mux = {27'h0000000, top_val[20:16]};
         RAS_OFS_CTRL:   rd_mux = {31'h00000000, ore};
         default:        rd_mux = 32'h00000000;
      endcase
   end
   wire rd_map = ras_mapped(s_araddr);

   assign s_awready = !aw_held;
   assign s_wready  = !w_held;
   assign s_arready = !s_rvalid;

   // axi write channel bookkeeping
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held  <= 1'b0;
         w_held   <= 1'b0;
         aw_addr  <= 8'h00;
         w_data   <= 32'h00000000;
         w_strb   <= 4'h0;
         s_bvalid <= 1'b0;
         s_bresp  <= RAS_RESP_OKAY;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_held <= 1'b1;
            aw_addr <= {s_awaddr[7:2], 2'b00};
         end
         if (s_wvalid && s_wready) begin
            w_held <= 1'b1;
            w_data <= s_wdata;
            w_strb <= s_wstrb;
         end
         if (wr_fire) begin
            s_bvalid <= 1'b1;
            s_bresp  <= wr_map ? RAS_RESP_OKAY : RAS_RESP_SLVERR;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
         end
      end
   end

   // axi read channel; data sampled at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_rvalid <= 1'b0;
         s_rdata  <= 32'h00000000;
         s_rresp  <= RAS_RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_rvalid <= 1'b1;
         s_rdata  <= rd_mux;
         s_rresp  <= rd_map ? RAS_RESP_OKAY : RAS_RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
         s_rvalid <= 1'b0;
      end
   end

   // pointer: core ops win over a software write in the same cycle,
   // since losing a return address is worse than losing a register write
   logic [RAS_PW-1:0] next_ptr;
   always_comb begin
      next_ptr = ptr;
      if (push_ovf)
         next_ptr = '0;
      else if (do_push && !at_full)
         next_ptr = ptr_inc;
      else if ((do_pop || do_drop) && !at_empty)
         next_ptr = ptr_dec;
      else if (wr_ptr && req.op == RAS_OP_NONE)
         next_ptr = w_data[RAS_PW-1:0];
   end

   // pointer and overflow or underflow reset request; pointer cleared by the device reset aresetn, not by por_n
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ptr              <= RAS_PTR_RESET[RAS_PW-1:0];
         device_reset_req <= 1'b0;
      end else begin
         ptr              <= next_ptr;
         device_reset_req <= push_ovf || (pop_unf && do_pop && ore);
      end
   end

   // sticky flags survive device resets; only power-on or software clear.
   // a hardware set in the same cycle as a clear wins
   always_ff @(posedge aclk) begin
      if (!por_n) begin
         full_flag  <= 1'b0;
         under_flag <= 1'b0;
         ore        <= RAS_ORE_RESET;
      end else begin
         if (do_push && (at_edge || at_full))
            full_flag <= 1'b1;
         else if (wr_ptr && !w_data[RAS_BIT_FULL])
            full_flag <= 1'b0;
         if (do_pop && at_empty)
            under_flag <= 1'b1;
         else if (wr_ptr && !w_data[RAS_BIT_UNDER])
            under_flag <= 1'b0;
         if (wr_ctrl)
            ore <= w_data[RAS_BIT_ORE];
      end
   end

   // storage: no reset, contents are undefined until pushed
   always_ff @(posedge aclk) begin
      if (do_push && !at_full)
         mem[ptr_inc] <= push_data;
      else if (!at_empty && (wr_lo || wr_hi || wr_up) && req.op == RAS_OP_NONE)
         mem[ptr] <= {wr_up ? w_data[4:0] : top_val[20:16],
                      merge8(top_val[15:8], w_data[7:0], wr_hi && w_strb[0]),
                      merge8(top_val[7:0], w_data[7:0], wr_lo && w_strb[0])};
   end

   // pop answer to the core: zero on underflow, latches untouched by design
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pop_pc    <= '0;
         pop_valid <= 1'b0;
      end else begin
         pop_valid <= do_pop;
         pop_pc    <= do_pop ? top_val : pop_pc;
      end
   end

   // fast shadow: interrupt vectoring or fast call overwrites it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shadow         <= '0;
         shadow_restore <= 1'b0;
      end else begin
         if (irq_vector || (do_push && req.fast_save))
            shadow <= live_regs;
         shadow_restore <= do_pop && req.fast_restore;
      end
   end
   assign shadow_regs = shadow;

   // assertions
   property p_push_inc;
      @(posedge aclk) disable iff (!aresetn)
      (do_push && !at_full && !push_ovf) |=> ptr == $past(ptr) + 5'h01;
   endproperty
   a_push_inc: assert property (p_push_inc) else $error("push did not advance pointer");
   property p_push_data;
      @(posedge aclk) disable iff (!aresetn)
      (do_push && !at_full && !push_ovf) |=> mem[ptr] == $past(req.pc);
   endproperty
   a_push_data: assert property (p_push_data) else $error("pushed pc not stored");
   property p_pop_dec;
      @(posedge aclk) disable iff (!aresetn)
      (do_pop && !at_empty) |=> ptr == $past(ptr) - 5'h01 && pop_valid;
   endproperty
   a_pop_dec: assert property (p_pop_dec) else $error("pop did not retreat pointer");
   property p_under;
      @(posedge aclk) disable iff (!aresetn)
      (do_pop && at_empty) |=> under_flag && ptr == '0 && pop_pc == '0;
   endproperty
   a_under: assert property (p_under) else $error("underflow handling wrong");
   property p_full_stop;
      @(posedge aclk) disable iff (!aresetn)
      (do_push && at_full) |=> ptr == RAS_PTR_MAX && full_flag && $stable(mem[RAS_DEPTH]);
   endproperty
   a_full_stop: assert property (p_full_stop) else $error("push past full moved");
   property p_ovf_rst;
      @(posedge aclk) disable iff (!aresetn)
      (do_push && at_edge && ore) |=> device_reset_req && full_flag && ptr == '0;
   endproperty
   a_ovf_rst: assert property (p_ovf_rst) else $error("overflow reset missing");
   property p_no_rst;
      @(posedge aclk) disable iff (!aresetn)
      !ore |=> !device_reset_req;
   endproperty
   a_no_rst: assert property (p_no_rst) else $error("reset without enable");
   property p_bit5;
      @(posedge aclk) disable iff (!aresetn)
      (s_arvalid && s_arready && s_araddr == RAS_OFS_PTR) |=>
         s_rdata[31:8] == 24'h000000 && s_rdata[7] == $past(full_flag) &&
         s_rdata[6] == $past(under_flag) && s_rdata[5] == 1'b0 &&
         s_rdata[4:0] == $past(ptr);
   endproperty
   a_bit5: assert property (p_bit5) else $error("pointer register layout");
   property p_shadow;
      @(posedge aclk) disable iff (!aresetn)
      irq_vector |=> shadow_regs == $past(live_regs);
   endproperty
   a_shadow: assert property (p_shadow) else $error("shadow not loaded");
   property p_drop;
      @(posedge aclk) disable iff (!aresetn)
      (do_drop && !at_empty) |=> !pop_valid && ptr == $past(ptr) - 5'h01;
   endproperty
   a_drop: assert property (p_drop) else $error("drop misbehaved");
   // sticky flags belong to the power-on domain: a device reset must not clear them
   property p_full_hold;
      @(posedge aclk) disable iff (!por_n)
      (full_flag && !(wr_ptr && !w_data[RAS_BIT_FULL])) |=> full_flag;
   endproperty
   a_full_hold: assert property (p_full_hold) else $error("full flag lost");
   property p_under_hold;
      @(posedge aclk) disable iff (!por_n)
      (under_flag && !(wr_ptr && !w_data[RAS_BIT_UNDER])) |=> under_flag;
   endproperty
   a_under_hold: assert property (p_under_hold) else $error("underflow flag lost");
   // the reset property has no disable: it watches the reset itself
   property p_rst_ptr;
      @(posedge aclk)
      !aresetn |=> ptr == '0;
   endproperty
   a_rst_ptr: assert property (p_rst_ptr) else $error("pointer not cleared by reset");
   // overflow and underflow consequences
   property p_ovf_data;
      @(posedge aclk) disable iff (!aresetn)
      (do_push && at_edge && ore) |=> mem[RAS_DEPTH] == $past(req.pc) + RAS_PC_STEP;
   endproperty
   a_ovf_data: assert property (p_ovf_data) else $error("overflow push not pc plus two");
   property p_full_set;
      @(posedge aclk) disable iff (!aresetn)
      (do_push && at_edge && !ore) |=> full_flag && ptr == RAS_PTR_MAX && !device_reset_req;
   endproperty
   a_full_set: assert property (p_full_set) else $error("31st push without enable wrong");
   property p_unf_rst;
      @(posedge aclk) disable iff (!aresetn)
      (do_pop && at_empty && ore) |=> device_reset_req && under_flag && ptr == '0;
   endproperty
   a_unf_rst: assert property (p_unf_rst) else $error("underflow reset missing");
   // software access; core operations take the cycle when both collide
   property p_ptr_wr;
      @(posedge aclk) disable iff (!aresetn)
      (wr_ptr && req.op == RAS_OP_NONE) |=> ptr == $past(w_data[RAS_PW-1:0]);
   endproperty
   a_ptr_wr: assert property (p_ptr_wr) else $error("pointer write lost");
   property p_top_wr;
      @(posedge aclk) disable iff (!aresetn)
      (wr_lo && w_strb[0] && !at_empty && req.op == RAS_OP_NONE) |=>
         mem[ptr][7:0] == $past(w_data[7:0]);
   endproperty
   a_top_wr: assert property (p_top_wr) else $error("top entry write lost");
   // fast shadow save and restore
   property p_fast_save;
      @(posedge aclk) disable iff (!aresetn)
      (do_push && req.fast_save) |=> shadow_regs == $past(live_regs);
   endproperty
   a_fast_save: assert property (p_fast_save) else $error("fast call did not save");
   property p_fast_rst;
      @(posedge aclk) disable iff (!aresetn)
      (do_pop && req.fast_restore) |=> shadow_restore;
   endproperty
   a_fast_rst: assert property (p_fast_rst) else $error("fast return did not restore");
   // covers: the core spaces its requests one idle cycle apart
   c_push: cover property (@(posedge aclk) disable iff (!aresetn) do_push ##2 do_pop);
   c_ovf:  cover property (@(posedge aclk) disable iff (!aresetn) push_ovf);
   c_full: cover property (@(posedge aclk) disable iff (!aresetn) push_blk);
   c_unf:  cover property (@(posedge aclk) disable iff (!aresetn) pop_unf);
   c_wr:   cover property (@(posedge aclk) disable iff (!aresetn) wr_lo);
endmodule

/* test/ras_core_model.sv */
/*
 behavioural model of the core's instruction execution and interrupt
 sequencing, standing on the far side of the return address stack.
 assumes the bench calls issue() once per instruction and reads the
 captured answer fields afterwards; all on the one core clock.
*/
module ras_core_model
   import ras_pkg::*;
(
   // clock
   input  wire logic                  aclk,
   // answers from the stack
   input  wire logic [RAS_AW-1:0]     pop_pc,
   input  wire logic                  pop_valid,
   input  wire logic                  shadow_restore,
   input  wire logic                  device_reset_req,
   input  wire ras_pkg::ras_shadow_s  shadow_regs,
   // requests to the stack
   output ras_pkg::ras_req_s          req,
   output logic                       irq_vector,
   output ras_pkg::ras_shadow_s       live_regs
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [RAS_AW-1:0] rpc;
   logic              rv, rst, srs;
   ras_shadow_s       shd;
   // idle core: no operation, no vectoring
   initial begin
      req = '0;
      irq_vector = 1'b0;
      live_regs = 24'h0;
   end
   // calls and interrupt acknowledge arrive as push, all returns as pop
   // the request is held for one edge only, so no instruction repeats
   task automatic issue(input ras_op_e op, input logic [RAS_AW-1:0] pc, input logic fs,
                        input logic fr, input logic irq, input ras_shadow_s lv);
      @(posedge aclk);
      req <= '{op: op, pc: pc, fast_save: fs, fast_restore: fr};
      irq_vector <= irq;
      live_regs <= lv;
      @(posedge aclk);
      req <= '0;
      irq_vector <= 1'b0;
      // one-cycle answers are read mid-cycle, after the edge has settled
      @(negedge aclk);
      rv = pop_valid;
      rpc = pop_pc;
      rst = device_reset_req;
      srs = shadow_restore;
      shd = shadow_regs;
   endtask
endmodule

/* test/return_address_stack_test.sv */
/*
 self-checking bench for the return address stack.
 assumes ras_stack as the design, ras_core_model as the core, a 100 MHz
 clock and a software master speaking AXI4-Lite on the same clock.
*/
module return_address_stack_test;
   timeunit 1ns;
   timeprecision 1ps;
   import ras_pkg::*;
   logic aclk, aresetn, por_n, irq_vector, pop_valid, shadow_restore, device_reset_req;
   ras_req_s req;
   ras_shadow_s live_regs, shadow_regs;
   logic [RAS_AW-1:0] pop_pc;
   logic [7:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata, rdv;
   logic [3:0] s_wstrb;
   logic [1:0] s_bresp, s_rresp, rsp;
   logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic s_arvalid, s_arready, s_rvalid, s_rready;
   int error_cnt, n_compared, i;
   ras_stack dut (.aclk, .aresetn, .por_n, .req, .irq_vector, .live_regs, .pop_pc, .pop_valid,
      .shadow_regs, .shadow_restore, .device_reset_req, .s_awaddr, .s_awvalid, .s_awready,
      .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
      .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
   ras_core_model core (.aclk, .pop_pc, .pop_valid, .shadow_restore, .device_reset_req,
      .shadow_regs, .req, .irq_vector, .live_regs);
   // free-running core clock
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic conclude();
      if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // handshakes are judged on ready seen mid-cycle, then released at the edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      tb = 1'b0;
      @(posedge aclk);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      for (int n = 0; n < 40 && !tb; n++) begin
         @(negedge aclk);
         ta = s_awvalid && s_awready;
         tw = s_wvalid && s_wready;
         tb = s_bvalid;
         rsp = s_bresp;
         @(posedge aclk);
         if (ta) s_awvalid <= 1'b0;
         if (tw) s_wvalid <= 1'b0;
         if (tb) s_bready <= 1'b0;
      end
      if (!tb) begin
         error_cnt++;
         conclude();
      end
   endtask
   task automatic rd(input logic [7:0] a);
      logic ta, tr;
      tr = 1'b0;
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      for (int n = 0; n < 40 && !tr; n++) begin
         @(negedge aclk);
         ta = s_arvalid && s_arready;
         tr = s_rvalid;
         rdv = s_rdata;
         rsp = s_rresp;
         @(posedge aclk);
         if (ta) s_arvalid <= 1'b0;
         if (tr) s_rready <= 1'b0;
      end
      if (!tr) begin
         error_cnt++;
         conclude();
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(rdv, exp);
   endtask
   task automatic op(input ras_op_e o, input logic [RAS_AW-1:0] pc);
      core.issue(o, pc, 1'b0, 1'b0, 1'b0, 24'h0);
   endtask
   task automatic pchk(input logic [31:0] exp);
      op(RAS_OP_POP, 21'h0);
      chk(32'(core.rv), 32'h1);
      chk(32'(core.rpc), exp);
   endtask
   // the system answers a reset request by pulsing the device reset only
   task automatic dev_reset();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
   endtask
   task automatic t_regs();
      rchk(RAS_OFS_PTR, 32'h0);
      rchk(RAS_OFS_CTRL, 32'h1);
      wr(RAS_OFS_PTR, 32'h25);
      chk({30'h0, rsp}, {30'h0, RAS_RESP_OKAY});
      rchk(RAS_OFS_PTR, 32'h05);
      rd(8'h14);
      chk({30'h0, rsp}, {30'h0, RAS_RESP_SLVERR});
      wr(8'h14, 32'h0);
      chk({30'h0, rsp}, {30'h0, RAS_RESP_SLVERR});
      wr(RAS_OFS_PTR, 32'h0);
   endtask
   task automatic t_push_pop();
      op(RAS_OP_PUSH, 21'h012344);
      op(RAS_OP_PUSH, 21'h1ABCDE);
      rchk(RAS_OFS_PTR, 32'h02);
      rchk(RAS_OFS_TOP_LO, 32'hDE);
      rchk(RAS_OFS_TOP_HI, 32'hBC);
      rchk(RAS_OFS_TOP_UP, 32'h1A);
      op(RAS_OP_PUSH, 21'h000456);
      rchk(RAS_OFS_PTR, 32'h03);
      op(RAS_OP_DROP, 21'h0);
      pchk(32'h1ABCDE);
      rchk(RAS_OFS_PTR, 32'h01);
      pchk(32'h012344);
   endtask
   task automatic t_shadow();
      core.issue(RAS_OP_PUSH, 21'h000200, 1'b0, 1'b0, 1'b1, 24'hA1B2C3);
      chk(32'(core.shd), 32'hA1B2C3);
      core.issue(RAS_OP_PUSH, 21'h000300, 1'b0, 1'b0, 1'b1, 24'h0F1E2D);
      chk(32'(core.shd), 32'h0F1E2D);
      core.issue(RAS_OP_POP, 21'h0, 1'b0, 1'b1, 1'b0, 24'h0);
      chk(32'(core.srs), 32'h1);
      chk(32'(core.rpc), 32'h000300);
      core.issue(RAS_OP_PUSH, 21'h000400, 1'b1, 1'b0, 1'b0, 24'h445566);
      chk(32'(core.shd), 32'h445566);
      core.issue(RAS_OP_POP, 21'h0, 1'b0, 1'b1, 1'b0, 24'h0);
      chk(32'(core.srs), 32'h1);
      pchk(32'h000200);
   endtask
   task automatic t_underflow();
      wr(RAS_OFS_CTRL, 32'h0);
      pchk(32'h0);
      chk(32'(core.rst), 32'h0);
      rchk(RAS_OFS_PTR, 32'h40);
      rchk(RAS_OFS_CTRL, 32'h0);
      wr(RAS_OFS_PTR, 32'h0);
      rchk(RAS_OFS_PTR, 32'h0);
   endtask
   task automatic t_top_write();
      op(RAS_OP_PUSH, 21'h000100);
      wr(RAS_OFS_TOP_LO, 32'h34);
      wr(RAS_OFS_TOP_HI, 32'h12);
      wr(RAS_OFS_TOP_UP, 32'h07);
      pchk(32'h071234);
   endtask
   task automatic t_fill();
      for (i = 1; i <= 30; i++) op(RAS_OP_PUSH, 21'(2 * i));
      rchk(RAS_OFS_PTR, 32'h1E);
      op(RAS_OP_PUSH, 21'd62);
      rchk(RAS_OFS_PTR, 32'h9F);
      op(RAS_OP_PUSH, 21'h1FFFFE);
      rchk(RAS_OFS_PTR, 32'h9F);
      pchk(32'd62);
      rchk(RAS_OFS_PTR, 32'h9E);
      wr(RAS_OFS_PTR, 32'h0);
   endtask
   task automatic t_overflow_reset();
      wr(RAS_OFS_CTRL, 32'h1);
      wr(RAS_OFS_PTR, 32'h1E);
      rchk(RAS_OFS_PTR, 32'h1E);
      op(RAS_OP_PUSH, 21'h000A00);
      chk(32'(core.rst), 32'h1);
      dev_reset();
      rchk(RAS_OFS_PTR, 32'h80);
      wr(RAS_OFS_PTR, 32'h9F);
      rchk(RAS_OFS_TOP_LO, 32'h02);
      rchk(RAS_OFS_TOP_HI, 32'h0A);
      wr(RAS_OFS_PTR, 32'h0);
      pchk(32'h0);
      chk(32'(core.rst), 32'h1);
      dev_reset();
      rchk(RAS_OFS_PTR, 32'h40);
   endtask
   // main sequence: both resets held six cycles, then the scenarios
   initial begin
      error_cnt = 0;
      n_compared = 0;
      aresetn = 1'b0;
      por_n = 1'b0;
      s_awaddr = 8'h00;
      s_araddr = 8'h00;
      s_wdata = 32'h0;
      s_wstrb = 4'h1;
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      por_n <= 1'b1;
      t_regs();
      t_push_pop();
      t_shadow();
      t_underflow();
      t_top_write();
      t_fill();
      t_overflow_reset();
      conclude();
   end
endmodule
